// *** src/ierc_control.sv ***
// enable, communication exit, wait release and bus status control
`timescale 1ns/1ps
`include "ierc_regs.svh"
module ierc_control
   import ierc_pkg::*;
#(
   parameter int HALF_CYCLES = `IERC_HALF_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [7:0] rdata,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_out,
   output logic scl_oe,
   output logic sda_out,
   output logic sda_oe,
   input wire logic wait_active,
   input wire logic ninth_clock_wait,
   input wire logic address_match,
   input wire logic extension_code,
   output logic standby,
   output logic wait_done
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic start_fail;
      logic bus_busy;
      logic init_state;
      logic rsv_disable;
      logic master;
      logic ext_code;
      logic addr_match;
      logic tx_dir;
      logic ack_det;
      logic start_det;
      logic stop_det;
      logic clk_level;
      logic data_level;
      logic standby;
      logic wait_done;
      logic enabled_old;
      logic scl_drive;
      logic sda_drive;
      ierc_gen_type gen;
      logic [15:0] timer;
      logic [7:0] rdata;
   } ierc_ctl_type;
   ierc_ctl_type state;
   ierc_ctl_type next_state;
   logic scl_level;
   logic sda_level;
   logic start_seen;
   logic stop_seen;
   ierc_line_monitor u_mon (
      .clk(clk),
      .rst(rst),
      .scl_in(scl_in),
      .sda_in(sda_in),
      .scl_level(scl_level),
      .sda_level(sda_level),
      .start_seen(start_seen),
      .stop_seen(stop_seen)
   );
   function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
      hit = (a == target);
   endfunction
   //////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic en;
      logic rising;
      logic timer_done;
      logic [7:0] status_view;
      logic [7:0] flag_view;
      logic [7:0] clk_view;
      en = 1'b0;
      rising = 1'b0;
      timer_done = 1'b0;
      status_view = 8'h00;
      flag_view = 8'h00;
      clk_view = 8'h00;
      next_state = state;
      next_state.wait_done = 1'b0;
      next_state.ctrl[`IERC_BIT_COMM_EXIT] = 1'b0;
      // register writes
      if (wr && hit(addr, `IERC_ADDR_CONTROL)) begin
         next_state.ctrl = wdata;
         // self-clearing bits act only when written as one
         next_state.ctrl[`IERC_BIT_COMM_EXIT] = 1'b0;
         next_state.ctrl[`IERC_BIT_WAIT_RELEASE] = state.ctrl[`IERC_BIT_WAIT_RELEASE]
            | wdata[`IERC_BIT_WAIT_RELEASE];
      end
      if (wr && hit(addr, `IERC_ADDR_FLAGS)) begin
         next_state.init_state = wdata[`IERC_BIT_INIT_STATE];
         next_state.rsv_disable = wdata[`IERC_BIT_RSV_DISABLE];
      end
      en = next_state.ctrl[`IERC_BIT_ENABLE];
      rising = en && !state.enabled_old;
      next_state.enabled_old = en;
      timer_done = (state.timer == 16'h0000);
      if (!timer_done) begin
         next_state.timer = state.timer - 16'h0001;
      end
      if (!en) begin
         // stopped: status, busy, fail and level monitors held cleared
         next_state.ctrl[`IERC_BIT_WAIT_RELEASE] = 1'b0;
         next_state.ctrl[`IERC_BIT_START_REQ] = 1'b0;
         next_state.ctrl[`IERC_BIT_STOP_REQ] = 1'b0;
         next_state.master = 1'b0;
         next_state.ext_code = 1'b0;
         next_state.addr_match = 1'b0;
         next_state.tx_dir = 1'b0;
         next_state.ack_det = 1'b0;
         next_state.start_det = 1'b0;
         next_state.stop_det = 1'b0;
         next_state.start_fail = 1'b0;
         next_state.bus_busy = 1'b0;
         next_state.clk_level = 1'b0;
         next_state.data_level = 1'b0;
         next_state.standby = 1'b0;
         next_state.scl_drive = 1'b0;
         next_state.sda_drive = 1'b0;
         next_state.gen = ierc_idle_type_v;
      end else begin
         next_state.clk_level = scl_level;
         next_state.data_level = sda_level;
         if (rising) begin
            next_state.bus_busy = state.init_state;
            if (scl_level && !sda_level) begin
               next_state.start_det = 1'b1;
               next_state.bus_busy = 1'b1;
            end
         end
         if (start_seen) begin
            next_state.bus_busy = 1'b1;
            next_state.start_det = 1'b1;
            next_state.stop_det = 1'b0;
         end
         if (stop_seen) begin
            next_state.bus_busy = 1'b0;
            next_state.stop_det = 1'b1;
            next_state.start_det = 1'b0;
            next_state.master = 1'b0;
            next_state.standby = 1'b0;
         end
         if (state.standby && state.start_det && (address_match || extension_code)) begin
            next_state.standby = 1'b0;
         end
         next_state.addr_match = next_state.addr_match | (address_match && !state.standby);
         next_state.ext_code = next_state.ext_code | (extension_code && !state.standby);
         // start request
         if (state.ctrl[`IERC_BIT_START_REQ] && state.gen == ierc_idle_type_v) begin
            if (state.rsv_disable && state.bus_busy) begin
               next_state.start_fail = 1'b1;
               next_state.ctrl[`IERC_BIT_START_REQ] = 1'b0;
            end else if (!state.bus_busy && !state.standby) begin
               next_state.gen = ierc_start_type_v;
               next_state.sda_drive = 1'b1;
               next_state.timer = 16'(HALF_CYCLES);
            end
         end
         // stop request
         if (state.ctrl[`IERC_BIT_STOP_REQ] && state.gen == ierc_hold_type_v) begin
            next_state.gen = ierc_stop_low_type_v;
            next_state.scl_drive = 1'b1;
            next_state.sda_drive = 1'b1;
            next_state.timer = 16'(HALF_CYCLES);
         end
         case (state.gen)
            ierc_start_type_v: begin
               if (timer_done) begin
                  next_state.gen = ierc_hold_type_v;
                  next_state.scl_drive = 1'b1;
                  next_state.master = 1'b1;
                  next_state.ctrl[`IERC_BIT_START_REQ] = 1'b0;
               end
            end
            ierc_stop_low_type_v: begin
               if (timer_done) begin
                  next_state.gen = ierc_stop_high_type_v;
                  next_state.scl_drive = 1'b0;
                  next_state.timer = 16'(HALF_CYCLES);
               end
            end
            ierc_stop_high_type_v: begin
               if (timer_done) begin
                  next_state.gen = ierc_idle_type_v;
                  next_state.sda_drive = 1'b0;
                  next_state.ctrl[`IERC_BIT_STOP_REQ] = 1'b0;
               end
            end
            ierc_idle_type_v: begin
            end
            ierc_hold_type_v: begin
            end
            default: begin
               next_state.gen = ierc_idle_type_v;
            end
         endcase
         // wait release
         if (state.ctrl[`IERC_BIT_WAIT_RELEASE]) begin
            if (wait_active) begin
               next_state.wait_done = 1'b1;
               next_state.ctrl[`IERC_BIT_WAIT_RELEASE] = 1'b0;
               if (ninth_clock_wait && state.tx_dir) begin
                  next_state.tx_dir = 1'b0;
                  next_state.sda_drive = 1'b0;
               end
            end else begin
               next_state.ctrl[`IERC_BIT_WAIT_RELEASE] = 1'b0;
            end
         end
         // communication exit, only honoured while enabled
         if (wr && hit(addr, `IERC_ADDR_CONTROL) && wdata[`IERC_BIT_COMM_EXIT]
             && state.ctrl[`IERC_BIT_ENABLE]) begin
            next_state.standby = 1'b1;
            next_state.scl_drive = 1'b0;
            next_state.sda_drive = 1'b0;
            next_state.gen = ierc_idle_type_v;
            next_state.ctrl[`IERC_BIT_START_REQ] = 1'b0;
            next_state.ctrl[`IERC_BIT_STOP_REQ] = 1'b0;
            next_state.master = 1'b0;
            next_state.ext_code = 1'b0;
            next_state.addr_match = 1'b0;
            next_state.tx_dir = 1'b0;
            next_state.ack_det = 1'b0;
            next_state.start_det = 1'b0;
         end
      end
      // read views
      status_view[`IERC_BIT_MASTER] = state.master;
      status_view[`IERC_BIT_EXT_CODE] = state.ext_code;
      status_view[`IERC_BIT_ADDR_MATCH] = state.addr_match;
      status_view[`IERC_BIT_TX_DIR] = state.tx_dir;
      status_view[`IERC_BIT_ACK_DET] = state.ack_det;
      status_view[`IERC_BIT_START_DET] = state.start_det;
      status_view[`IERC_BIT_STOP_DET] = state.stop_det;
      flag_view[`IERC_BIT_START_FAIL] = state.start_fail;
      flag_view[`IERC_BIT_BUS_BUSY] = state.bus_busy;
      flag_view[`IERC_BIT_INIT_STATE] = state.init_state;
      flag_view[`IERC_BIT_RSV_DISABLE] = state.rsv_disable;
      clk_view[`IERC_BIT_CLK_LEVEL] = state.clk_level;
      clk_view[`IERC_BIT_DATA_LEVEL] = state.data_level;
      next_state.rdata = 8'h00;
      if (rd) begin
         if (hit(addr, `IERC_ADDR_CONTROL)) begin
            next_state.rdata = state.ctrl;
         end else if (hit(addr, `IERC_ADDR_FLAGS)) begin
            next_state.rdata = flag_view;
         end else if (hit(addr, `IERC_ADDR_STATUS)) begin
            next_state.rdata = status_view;
         end else if (hit(addr, `IERC_ADDR_CLKSEL)) begin
            next_state.rdata = clk_view;
         end
      end
   end
   //////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '0;
         state.ctrl <= `IERC_CONTROL_RESET;
         state.gen <= ierc_idle_type_v;
      end else begin
         state <= next_state;
      end
   end
   assign rdata = state.rdata;
   assign scl_out = 1'b0;
   assign sda_out = 1'b0;
   assign scl_oe = state.scl_drive;
   assign sda_oe = state.sda_drive;
   assign standby = state.standby;
   assign wait_done = state.wait_done;
endmodule

// *** src/ierc_line_monitor.sv ***
// synchroniser and start/stop detector for the two bus lines
`timescale 1ns/1ps
module ierc_line_monitor
   import ierc_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic scl_level,
   output logic sda_level,
   output logic start_seen,
   output logic stop_seen
);
   typedef struct packed {
      logic [1:0] scl_sync;
      logic [1:0] sda_sync;
      logic scl_old;
      logic sda_old;
      logic start_p;
      logic stop_p;
   } ierc_mon_type;
   ierc_mon_type state;
   ierc_mon_type next_state;
   always_comb begin
      next_state = state;
      next_state.scl_sync = {state.scl_sync[0], scl_in};
      next_state.sda_sync = {state.sda_sync[0], sda_in};
      next_state.scl_old = state.scl_sync[1];
      next_state.sda_old = state.sda_sync[1];
      // data falling while clock high is a start, data rising a stop
      next_state.start_p = state.scl_sync[1] && state.scl_old && state.sda_old
         && !state.sda_sync[1];
      next_state.stop_p = state.scl_sync[1] && state.scl_old && !state.sda_old
         && state.sda_sync[1];
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         state <= '{scl_sync: 2'h3, sda_sync: 2'h3, scl_old: 1'b1, sda_old: 1'b1,
                    start_p: 1'b0, stop_p: 1'b0};
      end else begin
         state <= next_state;
      end
   end
   assign scl_level = state.scl_old;
   assign sda_level = state.sda_old;
   assign start_seen = state.start_p;
   assign stop_seen = state.stop_p;
endmodule

// *** src/ierc_pkg.sv ***
// types shared by the control block
package ierc_pkg;
   typedef enum logic [2:0] {
      ierc_idle_type_v = 3'h0,
      ierc_start_type_v = 3'h1,
      ierc_hold_type_v = 3'h3,
      ierc_stop_low_type_v = 3'h2,
      ierc_stop_high_type_v = 3'h6
   } ierc_gen_type;
endpackage

// *** src/ierc_regs.svh ***
// register offsets, field positions, reset values and timing counts
`ifndef IERC_REGS_SVH
`define IERC_REGS_SVH
`define IERC_ADDR_CONTROL 16'hFFA6
`define IERC_ADDR_FLAGS 16'hFFA7
`define IERC_ADDR_STATUS 16'hFFA8
`define IERC_ADDR_CLKSEL 16'hFFA9
`define IERC_CONTROL_RESET 8'h00
`define IERC_FLAGS_RESET 8'h00
`define IERC_BIT_WAIT_RELEASE 7
`define IERC_BIT_ENABLE 6
`define IERC_BIT_COMM_EXIT 5
`define IERC_BIT_STOP_IRQ_EN 4
`define IERC_BIT_WAIT_TIMING 3
`define IERC_BIT_ACK_ENABLE 2
`define IERC_BIT_START_REQ 1
`define IERC_BIT_STOP_REQ 0
`define IERC_BIT_START_FAIL 7
`define IERC_BIT_BUS_BUSY 6
`define IERC_BIT_INIT_STATE 1
`define IERC_BIT_RSV_DISABLE 0
`define IERC_BIT_MASTER 7
`define IERC_BIT_EXT_CODE 6
`define IERC_BIT_ADDR_MATCH 5
`define IERC_BIT_TX_DIR 4
`define IERC_BIT_ACK_DET 2
`define IERC_BIT_START_DET 1
`define IERC_BIT_STOP_DET 0
`define IERC_BIT_CLK_LEVEL 5
`define IERC_BIT_DATA_LEVEL 4
`define IERC_CLK_HZ 20000000
`define IERC_HALF_NS 5000
`define IERC_HALF_CYCLES ((`IERC_HALF_NS * (`IERC_CLK_HZ / 1000000) + 999) / 1000)
`endif

// *** testbench/ierc_bus_peer.sv ***
// open-drain bus with pull-ups and a second master on it
`timescale 1ns/1ps
module ierc_bus_peer (
   input wire logic dut_scl_oe,
   input wire logic dut_sda_oe,
   output logic scl_line,
   output logic sda_line
);
   logic peer_scl_oe = 1'b0;
   logic peer_sda_oe = 1'b0;
   // a released line is pulled high
   assign scl_line = !(dut_scl_oe || peer_scl_oe);
   assign sda_line = !(dut_sda_oe || peer_sda_oe);
   // data falls while clock high, then the clock is held low
   task automatic make_start();
      #200 peer_sda_oe = 1'b1;
      #200 peer_scl_oe = 1'b1;
   endtask
   // clock rises first, data rises while clock high
   task automatic make_stop();
      peer_sda_oe = 1'b1;
      #200 peer_scl_oe = 1'b0;
      #200 peer_sda_oe = 1'b0;
      #200;
   endtask
   // repeated start with no stop: free data, let the clock rise, then start again
   task automatic make_restart();
      peer_sda_oe = 1'b0;
      #200 peer_scl_oe = 1'b0;
      make_start();
   endtask
   task automatic hold_data(input logic v);
      peer_sda_oe = v;
   endtask
endmodule

// *** testbench/ierc_control_asserts.sv ***
// port checker for the control block
`timescale 1ns/1ps
`include "ierc_regs.svh"
module ierc_control_asserts
   import ierc_pkg::*;
#(
   parameter int HALF_CYCLES = 4
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [15:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic scl_oe,
   input wire logic sda_oe,
   input wire logic standby,
   input wire logic wait_done
);
   localparam int HMAX = HALF_CYCLES + 2;
   logic [1:0] wrel_age;
   logic ctl_wr;
   assign ctl_wr = wr && addr == `IERC_ADDR_CONTROL;
   // cycles since the last wait release write, saturating
   always_ff @(posedge clk) begin
      if (rst) begin
         wrel_age <= 2'h3;
      end else if (ctl_wr && wdata[7]) begin
         wrel_age <= 2'h0;
      end else if (wrel_age != 2'h3) begin
         wrel_age <= wrel_age + 2'h1;
      end
   end
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   reset_quiet_a: assert property ($fell(rst) |-> !scl_oe && !sda_oe && !standby)
      else $error("lines or standby active after reset");
   exit_cause_a: assert property ($rose(standby) |-> $past(ctl_wr) && $past(wdata[5]))
      else $error("standby entered without an exit write");
   exit_release_a: assert property (standby |-> !scl_oe && !sda_oe)
      else $error("line driven during standby");
   wait_pulse_a: assert property (wait_done |=> !wait_done)
      else $error("wait release pulse longer than one cycle");
   wait_cause_a: assert property (wait_done |-> wrel_age <= 2'h2)
      else $error("wait released without a release write");
   start_order_a: assert property ($rose(scl_oe) |-> $past(sda_oe))
      else $error("clock pulled low before data in start");
   start_time_a: assert property ($rose(sda_oe) && !scl_oe |-> ##[1:HMAX] scl_oe)
      else $error("start not followed by clock low in time");
   stop_order_a: assert property ($fell(sda_oe) |-> !scl_oe)
      else $error("data released while clock held low");
   stop_time_a: assert property ($fell(scl_oe) && sda_oe |-> ##[1:HMAX] !sda_oe)
      else $error("stop not completed in time");
   cover property ($rose(standby));
   cover property (wait_done);
   cover property ($rose(scl_oe));
endmodule
bind ierc_control ierc_control_asserts #(.HALF_CYCLES(HALF_CYCLES)) i_chk (
   .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .scl_oe(scl_oe),
   .sda_oe(sda_oe), .standby(standby), .wait_done(wait_done)
);

// *** testbench/ierc_control_tb.sv ***
// testbench for the control block
`timescale 1ns/1ps
`include "ierc_regs.svh"
module ierc_control_tb;
   localparam logic [15:0] A_CTL = `IERC_ADDR_CONTROL;
   localparam logic [15:0] A_FLG = `IERC_ADDR_FLAGS;
   localparam logic [15:0] A_STS = `IERC_ADDR_STATUS;
   localparam logic [15:0] A_CKS = `IERC_ADDR_CLKSEL;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [15:0] addr = 16'h0000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic wait_active = 1'b0;
   logic ninth_clock_wait = 1'b0;
   logic address_match = 1'b0;
   logic extension_code = 1'b0;
   logic [7:0] rdata;
   logic scl_out, scl_oe, sda_out, sda_oe, standby, wait_done, scl_line, sda_line;
   int mismatches = 0;
   int n_compared = 0;
   int cycles = 0;
   initial begin
      forever #25 clk = ~clk;
   end
   ierc_control #(.HALF_CYCLES(4)) i_dut (
      .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .scl_in(scl_line), .sda_in(sda_line), .scl_out(scl_out), .scl_oe(scl_oe),
      .sda_out(sda_out), .sda_oe(sda_oe), .wait_active(wait_active),
      .ninth_clock_wait(ninth_clock_wait), .address_match(address_match),
      .extension_code(extension_code), .standby(standby), .wait_done(wait_done)
   );
   ierc_bus_peer i_peer (
      .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line)
   );
   ////////////////////////////////////////////////////////////////////////////////
   task automatic wreg(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bchk(input logic b, input logic e);
      chk({7'h00, b}, {7'h00, e});
   endtask
   task automatic rchk(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata & m, e);
   endtask
   task automatic settle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic wait_oe(input logic pick_sda, input logic lvl);
      for (int k = 0; k < 30 && (pick_sda ? sda_oe : scl_oe) !== lvl; k++) begin
         @(negedge clk);
      end
   endtask
   task automatic pulse_seen(output logic s);
      s = 1'b0;
      repeat (3) begin
         @(negedge clk);
         s = s | (wait_done === 1'b1);
      end
   endtask
   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask
   task automatic give_verdict();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         give_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      logic s;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rchk(A_CTL, 8'hFF, 8'h00);
      rchk(A_FLG, 8'hFF, 8'h00);
      rchk(16'h0000, 8'hFF, 8'h00);
      end_test("reset");
      wreg(A_CTL, 8'hE0);
      settle(2);
      bchk(standby, 1'b0);
      rchk(A_CTL, 8'hFF, 8'h40);
      wreg(A_CTL, 8'h00);
      wreg(A_FLG, 8'h02);
      wreg(A_CTL, 8'h40);
      settle(4);
      rchk(A_FLG, 8'hFF, 8'h42);
      rchk(A_CKS, 8'h30, 8'h30);
      wreg(A_CTL, 8'h00);
      rchk(A_FLG, 8'hFF, 8'h02);
      rchk(A_CKS, 8'h30, 8'h00);
      end_test("init_state");
      wreg(A_FLG, 8'h00);
      wreg(A_CTL, 8'h5C);
      rchk(A_CTL, 8'hFF, 8'h5C);
      for (int i = 0; i < 3; i++) begin
         i_peer.make_start();
         settle(8);
         rchk(A_FLG, 8'h40, 8'h40);
         rchk(A_STS, 8'h02, 8'h02);
         wreg(A_CTL, 8'h7C);
         settle(1);
         bchk(standby, 1'b1);
         bchk(scl_oe | sda_oe, 1'b0);
         rchk(A_CTL, 8'hFF, 8'h5C);
         rchk(A_STS, 8'hF6, 8'h00);
         wreg(A_CTL, 8'h5C);
         settle(2);
         bchk(standby, 1'b1);
         if (i > 0) begin
            // the exit dropped the old start, so a fresh one must precede the match
            i_peer.make_restart();
            settle(8);
            rchk(A_STS, 8'h02, 8'h02);
            bchk(standby, 1'b1);
            @(posedge clk);
            address_match <= (i == 1);
            extension_code <= (i == 2);
            @(posedge clk);
            address_match <= 1'b0;
            extension_code <= 1'b0;
            settle(2);
            bchk(standby, 1'b0);
         end
         i_peer.make_stop();
         settle(8);
         bchk(standby, 1'b0);
         rchk(A_FLG, 8'h40, 8'h00);
      end
      end_test("exit");
      @(posedge clk);
      wait_active <= 1'b1;
      ninth_clock_wait <= 1'b1;
      wreg(A_CTL, 8'h5C);
      pulse_seen(s);
      bchk(s, 1'b0);
      wreg(A_CTL, 8'hDC);
      pulse_seen(s);
      bchk(s, 1'b1);
      rchk(A_CTL, 8'hFF, 8'h5C);
      @(posedge clk);
      wait_active <= 1'b0;
      ninth_clock_wait <= 1'b0;
      end_test("wait");
      wreg(A_CTL, 8'h00);
      wreg(A_FLG, 8'h03);
      wreg(A_CTL, 8'h40);
      wreg(A_CTL, 8'h42);
      settle(10);
      bchk(sda_oe, 1'b0);
      rchk(A_FLG, 8'hFF, 8'hC3);
      rchk(A_CTL, 8'h02, 8'h00);
      wreg(A_CTL, 8'h00);
      rchk(A_FLG, 8'hFF, 8'h03);
      end_test("refused");
      wreg(A_FLG, 8'h00);
      wreg(A_CTL, 8'h40);
      wreg(A_CTL, 8'h42);
      wait_oe(1'b0, 1'b1);
      bchk(sda_oe, 1'b1);
      rchk(A_STS, 8'h80, 8'h80);
      rchk(A_CTL, 8'h02, 8'h00);
      wreg(A_CTL, 8'h41);
      wait_oe(1'b1, 1'b0);
      bchk(scl_oe, 1'b0);
      rchk(A_CTL, 8'h01, 8'h00);
      end_test("start_stop");
      wreg(A_CTL, 8'h00);
      i_peer.hold_data(1'b1);
      settle(4);
      wreg(A_CTL, 8'h40);
      settle(4);
      rchk(A_STS, 8'h02, 8'h02);
      wreg(A_CTL, 8'h60);
      rchk(A_STS, 8'h02, 8'h00);
      i_peer.hold_data(1'b0);
      settle(8);
      wreg(A_CTL, 8'h00);
      rchk(A_STS, 8'hFF, 8'h00);
      end_test("early_start");
      give_verdict();
   end
endmodule
